// >>> fmr_regs.sv
// Register bank for the fractional modulator seed, numerator, denominator,
// order, reset and the two RF output level and power-down controls.
// Assumes a same-clock register port and an optional same-clock soft reset.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module fmr_regs (
  input  wire logic        core_clk,   // Core clock, 250 MHz.
  input  wire logic        arst_n,     // Asynchronous reset, active low.
  input  wire logic        soft_rst,   // Software reset pulse.
  input  wire logic [6:0]  reg_addr,   // Register offset.
  input  wire logic [15:0] reg_wdata,  // Write data.
  input  wire logic        reg_wr,     // Write strobe.
  input  wire logic        reg_rd,     // Read strobe.
  output fmr_pkg::fmr_frac_t frac_cfg, // Settings to fractional engine.
  output fmr_pkg::fmr_out_t  out_cfg,  // Settings to output buffers.
  output logic             seed_load,  // Load seed into engine, pulse.
  output logic      [15:0] reg_rdata   // Read data, cycle after strobe.
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_TAB [fmr_pkg::REG_COUNT] = '{
    fmr_pkg::RST_SEED_CTL,
    fmr_pkg::RST_DEN,
    fmr_pkg::RST_DEN,
    fmr_pkg::RST_ZERO,
    fmr_pkg::RST_ZERO,
    fmr_pkg::RST_ZERO,
    fmr_pkg::RST_ZERO,
    fmr_pkg::RST_CTRL,
    fmr_pkg::RST_OUTB,
    fmr_pkg::RST_FIX_A,
    fmr_pkg::RST_FIX_B,
    fmr_pkg::RST_FIX_C
  };

  logic [15:0] regq [fmr_pkg::REG_COUNT];
  logic [6:0]  idx;
  logic        hit;

  assign idx = reg_addr - fmr_pkg::OFS_SEED_CTL;
  assign hit = (reg_addr >= fmr_pkg::OFS_SEED_CTL) &&
               (reg_addr <= fmr_pkg::OFS_FIX_C);

  for (genvar i = 0; i < fmr_pkg::REG_COUNT; i++) begin : g_reg
    fmr_reg_cell #(
      .RESET_VAL (RST_TAB[i])
    ) u_cell (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .soft_rst (soft_rst),
      .wr_en    (reg_wr && hit && (idx == 7'(i))),
      .wdata    (reg_wdata),
      .q        (regq[i])
    );
  end

  logic [15:0] seed_ctl;
  logic [15:0] ctrl;
  logic [15:0] outb;

  assign seed_ctl = regq[0];
  assign ctrl     = regq[7];
  assign outb     = regq[8];

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd && hit) begin
      nxt_rdata = regq[idx[3:0]];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ---------------------------------------------------------------
  // Field decode towards engine and buffers
  // ---------------------------------------------------------------
  fmr_pkg::fmr_frac_t frac_ff;
  fmr_pkg::fmr_frac_t nxt_frac;
  fmr_pkg::fmr_out_t  outc_ff;
  fmr_pkg::fmr_out_t  nxt_outc;
  logic               load_ff;
  logic               nxt_load;
  logic               run_d_ff;

  always_comb begin
    nxt_frac.seed_en      = seed_ctl[fmr_pkg::SEED_EN_BIT];
    nxt_frac.seed         = nxt_frac.seed_en ?
                            {regq[3], regq[4]} : 32'h0000_0000;
    nxt_frac.numerator    = {regq[5], regq[6]};
    nxt_frac.denominator  = {regq[1], regq[2]};
    nxt_frac.order        = ctrl[fmr_pkg::ORDER_HI:0];
    nxt_frac.integer_mode = (nxt_frac.order == 3'h0);
    nxt_frac.order_unused = (nxt_frac.order > fmr_pkg::ORDER_MAX);
    nxt_frac.run          = ctrl[fmr_pkg::MOD_RUN_BIT];
    nxt_outc.a_level      = ctrl[fmr_pkg::A_LVL_HI:fmr_pkg::A_LVL_LO];
    nxt_outc.b_level      = outb[fmr_pkg::B_LVL_HI:0];
    nxt_outc.a_powerdown  = ctrl[fmr_pkg::A_PD_BIT];
    nxt_outc.b_powerdown  = ctrl[fmr_pkg::B_PD_BIT];
    // seed loads when the modulator leaves reset.
    nxt_load = nxt_frac.run && !run_d_ff;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frac_ff  <= '{seed: 32'h0, seed_en: 1'b0, numerator: 32'h0,
                    denominator: 32'hffff_ffff, order: 3'h2,
                    integer_mode: 1'b0, order_unused: 1'b0, run: 1'b1};
      outc_ff  <= '{a_level: 6'h08, b_level: 6'h08,
                    a_powerdown: 1'b0, b_powerdown: 1'b1};
      load_ff  <= 1'b0;
      run_d_ff <= 1'b1;
    end else begin
      frac_ff  <= nxt_frac;
      outc_ff  <= nxt_outc;
      load_ff  <= nxt_load;
      run_d_ff <= nxt_frac.run;
    end
  end

  assign frac_cfg  = frac_ff;
  assign out_cfg   = outc_ff;
  assign seed_load = load_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_seed_halves: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    frac_cfg.seed_en |-> frac_cfg.seed == {$past(regq[3]), $past(regq[4])})
    else $error("seed halves out of order");

  a_seed_gate: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !frac_cfg.seed_en |-> frac_cfg.seed == 32'h0)
    else $error("seed passed while disabled");

  a_num_write: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (reg_wr && reg_addr == fmr_pkg::OFS_NUM_HI && !soft_rst) |-> ##2
    frac_cfg.numerator[31:16] == $past(reg_wdata, 2))
    else $error("numerator upper half not applied");

  a_soft_fixed: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    soft_rst |=> (regq[9] == fmr_pkg::RST_FIX_A) &&
    (regq[10] == fmr_pkg::RST_FIX_B) && (regq[11] == fmr_pkg::RST_FIX_C))
    else $error("fixed words not restored");

  a_soft_clear: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    soft_rst |=> regq[3] == 16'h0 && regq[6] == 16'h0)
    else $error("seed or numerator not cleared");

  a_ctrl_reset: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    soft_rst |=> ctrl == fmr_pkg::RST_CTRL && outb == fmr_pkg::RST_OUTB)
    else $error("control reset value wrong");

  a_pd_follow: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ##1 out_cfg.b_powerdown == $past(ctrl[fmr_pkg::B_PD_BIT]) &&
    out_cfg.a_powerdown == $past(ctrl[fmr_pkg::A_PD_BIT]))
    else $error("power-down does not follow control");

  a_order_int: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    frac_cfg.integer_mode |-> frac_cfg.order == 3'h0 &&
    !frac_cfg.order_unused)
    else $error("integer mode with nonzero order");

  a_run_load: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    $rose(frac_cfg.run) |-> seed_load ##1 !seed_load)
    else $error("seed load missing after modulator release");

  a_read_data: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == fmr_pkg::OFS_CTRL) |=> reg_rdata == $past(ctrl))
    else $error("read data wrong");

  a_level_follow: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ##1 out_cfg.a_level ==
    $past(ctrl[fmr_pkg::A_LVL_HI:fmr_pkg::A_LVL_LO]) &&
    out_cfg.b_level == $past(outb[fmr_pkg::B_LVL_HI:0]))
    else $error("output level does not follow its register");

  a_num_low: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (reg_wr && reg_addr == fmr_pkg::OFS_NUM_LO && !soft_rst) |-> ##2
    frac_cfg.numerator[15:0] == $past(reg_wdata, 2))
    else $error("numerator lower half not applied");

  a_load_cause: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    seed_load |-> frac_cfg.run && !$past(frac_cfg.run))
    else $error("seed load without modulator release");

endmodule : fmr_regs

// >>> fmr_pkg.sv
// Constants, register map and carrier types for the modulator register bank.
// Assumes one core clock and a same-clock register port with 16-bit words.
// Function
// - 32-bit seed is upper register then lower register, starts engine.
// - Seed reaches the engine only while the seed enable bit is 1.
// - Numerator upper half at lower address, lower half next.
// - 32-bit denominator in two registers, both reset to all ones.
// - Output A level is bits 13:8, resets to 8.
// - Output B level is bits 5:0 of its register, resets to 8.
// - Bit 7 set powers down output B; resets to 1.
// - Bit 6 set powers down output A; resets to 0.
// - Bit 5 low holds modulator in reset; resets to 1.
// - Order 0 integer, 1 to 4 order, 5 to 7 unused; resets 2.
// - Software reset restores the fixed words to their required values.
// - Seed and numerator registers reset to zero.
// - Control resets to 08A2h, output B register resets to C608h.

package fmr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 7;
  localparam int          DATA_W       = 16;
  localparam int          REG_COUNT    = 12;
  localparam logic [6:0]  OFS_SEED_CTL = 7'h25;
  localparam logic [6:0]  OFS_DEN_HI   = 7'h26;
  localparam logic [6:0]  OFS_DEN_LO   = 7'h27;
  localparam logic [6:0]  OFS_SEED_HI  = 7'h28;
  localparam logic [6:0]  OFS_SEED_LO  = 7'h29;
  localparam logic [6:0]  OFS_NUM_HI   = 7'h2a;
  localparam logic [6:0]  OFS_NUM_LO   = 7'h2b;
  localparam logic [6:0]  OFS_CTRL     = 7'h2c;
  localparam logic [6:0]  OFS_OUTB     = 7'h2d;
  localparam logic [6:0]  OFS_FIX_A    = 7'h2e;
  localparam logic [6:0]  OFS_FIX_B    = 7'h2f;
  localparam logic [6:0]  OFS_FIX_C    = 7'h30;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_SEED_CTL = 16'h0205;
  localparam logic [15:0] RST_DEN      = 16'hffff;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam logic [15:0] RST_CTRL     = 16'h08a2;
  localparam logic [15:0] RST_OUTB     = 16'hc608;
  localparam logic [15:0] RST_FIX_A    = 16'h07f0;
  localparam logic [15:0] RST_FIX_B    = 16'h0300;
  localparam logic [15:0] RST_FIX_C    = 16'h03e0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SEED_EN_BIT = 15;
  localparam int A_LVL_HI    = 13;
  localparam int A_LVL_LO    = 8;
  localparam int B_PD_BIT    = 7;
  localparam int A_PD_BIT    = 6;
  localparam int MOD_RUN_BIT = 5;
  localparam int ORDER_HI    = 2;
  localparam int B_LVL_HI    = 5;
  localparam int LVL_W       = 6;
  localparam int ORDER_W     = 3;
  localparam logic [2:0] ORDER_MAX = 3'h4;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] seed;
    logic        seed_en;
    logic [31:0] numerator;
    logic [31:0] denominator;
    logic [2:0]  order;
    logic        integer_mode;
    logic        order_unused;
    logic        run;
  } fmr_frac_t;

  typedef struct packed {
    logic [5:0] a_level;
    logic [5:0] b_level;
    logic       a_powerdown;
    logic       b_powerdown;
  } fmr_out_t;

endpackage : fmr_pkg

// >>> fmr_reg_cell.sv
// One 16-bit software register with a reset value.
// Assumes write strobes come from logic on the same clock.
`timescale 1ns/1ps

module fmr_reg_cell #(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic        core_clk,  // Core clock.
  input  wire logic        arst_n,    // Asynchronous reset, active low.
  input  wire logic        soft_rst,  // Restores the reset value.
  input  wire logic        wr_en,     // Write this register.
  input  wire logic [15:0] wdata,     // Write data.
  output logic      [15:0] q          // Stored value.
);

  logic [15:0] val_ff;
  logic [15:0] nxt_val;

  always_comb begin
    nxt_val = val_ff;
    if (soft_rst) begin
      nxt_val = RESET_VAL;
    end else if (wr_en) begin
      nxt_val = wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      val_ff <= RESET_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;

endmodule : fmr_reg_cell

// >>> test_fmr_regs.sv
// Self-checking bench for the modulator register bank.
// Assumes the design carries its own assertions; no partner model is used.
`timescale 1ns/1ps

module test_fmr_regs;
  logic               core_clk;
  logic               arst_n;
  logic               soft_rst;
  logic [6:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  fmr_pkg::fmr_frac_t frac_cfg;
  fmr_pkg::fmr_out_t  out_cfg;
  logic               seed_load;
  logic [15:0]        reg_rdata;
  int                 n_errors;
  int                 num_checks;

  fmr_regs dut (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .soft_rst  (soft_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .frac_cfg  (frac_cfg),
    .out_cfg   (out_cfg),
    .seed_load (seed_load),
    .reg_rdata (reg_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({16'h0000, reg_rdata}, {16'h0000, e});
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] e [12] = '{fmr_pkg::RST_SEED_CTL, 16'hffff, 16'hffff,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, fmr_pkg::RST_CTRL,
      fmr_pkg::RST_OUTB, 16'h07f0, 16'h0300, 16'h03e0};
    for (int i = 0; i < 12; i++) begin
      rdchk(fmr_pkg::OFS_SEED_CTL + 7'(i), e[i]);
    end
    chk(frac_cfg.denominator, 32'hffffffff);
    chk(32'(frac_cfg.order), 32'h2);
    chk(32'(frac_cfg.run), 32'h1);
    chk(32'(out_cfg), 32'(14'b001000_001000_0_1));
    $display("t_reset finished");
  endtask : t_reset

  task automatic t_pairs();
    wr(fmr_pkg::OFS_SEED_HI, 16'h1234);
    wr(fmr_pkg::OFS_SEED_LO, 16'h5678);
    wr(fmr_pkg::OFS_NUM_HI, 16'h9abc);
    wr(fmr_pkg::OFS_NUM_LO, 16'hdef0);
    wr(fmr_pkg::OFS_DEN_HI, 16'h0001);
    wr(fmr_pkg::OFS_DEN_LO, 16'h0002);
    settle();
    chk(frac_cfg.seed, 32'h00000000);
    chk(frac_cfg.numerator, 32'h9abcdef0);
    chk(frac_cfg.denominator, 32'h00010002);
    wr(fmr_pkg::OFS_SEED_CTL, 16'h8205);
    settle();
    chk(frac_cfg.seed, 32'h12345678);
    chk(32'(frac_cfg.seed_en), 32'h1);
    rdchk(fmr_pkg::OFS_SEED_LO, 16'h5678);
    rdchk(fmr_pkg::OFS_NUM_HI, 16'h9abc);
    $display("t_pairs finished");
  endtask : t_pairs

  task automatic t_ctrl();
    int cnt = 0;
    for (int o = 0; o < 8; o++) begin
      wr(fmr_pkg::OFS_CTRL, 16'h1260 | 16'(o));
      settle();
      chk(32'({frac_cfg.order, frac_cfg.integer_mode,
               frac_cfg.order_unused}), 32'({3'(o), o == 0, o > 4}));
      chk(32'(out_cfg), 32'({6'h12, 6'h08, 1'b1, 1'b0}));
    end
    wr(fmr_pkg::OFS_OUTB, 16'hc611);
    settle();
    chk(32'(out_cfg.b_level), 32'h11);
    wr(fmr_pkg::OFS_CTRL, 16'h1282);
    settle();
    chk(32'({frac_cfg.run, out_cfg.b_powerdown}), 32'h1);
    wr(fmr_pkg::OFS_CTRL, 16'h12a2);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      #1 cnt += int'(seed_load === 1'b1);
    end
    chk(32'(cnt), 32'h1);
    $display("t_ctrl finished");
  endtask : t_ctrl

  task automatic t_soft();
    wr(fmr_pkg::OFS_FIX_A, fmr_pkg::RST_FIX_A);
    wr(7'h31, 16'habcd);
    rdchk(7'h31, 16'h0000);
    rdchk(fmr_pkg::OFS_FIX_A, fmr_pkg::RST_FIX_A);
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    rdchk(fmr_pkg::OFS_FIX_A, fmr_pkg::RST_FIX_A);
    rdchk(fmr_pkg::OFS_OUTB, fmr_pkg::RST_OUTB);
    rdchk(fmr_pkg::OFS_CTRL, fmr_pkg::RST_CTRL);
    rdchk(fmr_pkg::OFS_SEED_HI, fmr_pkg::RST_ZERO);
    rdchk(fmr_pkg::OFS_NUM_LO, fmr_pkg::RST_ZERO);
    chk(32'(out_cfg), 32'(14'b001000_001000_0_1));
    $display("t_soft finished");
  endtask : t_soft

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    arst_n    = 1'b0;
    soft_rst  = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    n_errors   = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_pairs();
    t_ctrl();
    t_soft();
    print_verdict();
  end
endmodule : test_fmr_regs
